/* common/dciv_pkg.sv */
// dciv_pkg.sv: types shared by the dma channel interrupt and validation
// block; constants live in dciv_regs.svh.
// assumes the header is compiled alongside.
`include "dciv_regs.svh"

package dciv_pkg;

  // ------------------------------------------------------------
  // channel vector and per-channel descriptor events
  // ------------------------------------------------------------
  typedef logic [`DCIV_NUM_CH-1:0] dciv_chvec_t;

  // descriptor events reported by the transfer engine, one bit per channel
  typedef struct packed {
    dciv_chvec_t exhausted;     // descriptor finished this cycle
    dciv_chvec_t irq_a_request; // descriptor_irq_a_request of it
    dciv_chvec_t irq_b_request; // descriptor_irq_b_request of it
    dciv_chvec_t error;         // transfer error this cycle
  } dciv_events_t;

  // validity check requested by the transfer engine
  typedef struct packed {
    dciv_chvec_t check;      // a new descriptor was loaded
    dciv_chvec_t valid_bit;  // its descriptor_valid_bit
  } dciv_desc_t;

  typedef enum logic [1:0] {
    DCIV_IDLE,
    DCIV_RUN,
    DCIV_HALT
  } dciv_state_t;

endpackage : dciv_pkg

/* common/dciv_regs.svh */
// dciv_regs.svh: register offsets, widths and reset values of the dma
// channel interrupt and validation block.
// assumes a single clock domain and a 32-bit axi4-lite register bus.
`ifndef DCIV_REGS_SVH
`define DCIV_REGS_SVH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define DCIV_OFS_ERR_STATUS 8'h40
`define DCIV_OFS_IRQ_EN_SET 8'h48
`define DCIV_OFS_IRQ_EN_CLR 8'h50
`define DCIV_OFS_IRQ_A_STATUS 8'h58
`define DCIV_OFS_IRQ_B_STATUS 8'h60
`define DCIV_OFS_VALID_SET 8'h68
`define DCIV_OFS_EVENT_STATUS 8'h6C

// ------------------------------------------------------------
// field layout and reset values
// ------------------------------------------------------------
`define DCIV_NUM_CH 19
`define DCIV_ADDR_W 8
`define DCIV_CH_RESET 19'h00000
`define DCIV_RESP_OKAY 2'h0
`define DCIV_RESP_SLVERR 2'h2

`endif

/* rtl/dciv_dma_irq_valid.sv */
// dciv_dma_irq_valid.sv: per-channel interrupt enables, a/b/error status,
// shared interrupt line and descriptor validation with pending release.
// assumes the transfer engine reports descriptor events on SYS_CLK and
// holds a channel while its hold output is high.
//
// The AXI4-Lite slave port is this design's own decision.
`include "dciv_regs.svh"

module dciv_dma_irq_valid
  import dciv_pkg::*;
#(
  parameter int NUM_CH = `DCIV_NUM_CH
)
(
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RESETN,
  // axi4-lite write address and data
  input wire logic [`DCIV_ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  // axi4-lite write response
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  // axi4-lite read
  input wire logic [`DCIV_ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // transfer engine side
  input wire dciv_events_t DESC_EVENTS,
  input wire dciv_desc_t DESC_CHECK,
  output dciv_chvec_t DESC_GO,
  output dciv_chvec_t DESC_HOLD,
  // shared interrupt
  output logic DMA_IRQ
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  dciv_chvec_t irq_enable;
  dciv_chvec_t irq_a_flag;
  dciv_chvec_t irq_b_flag;
  dciv_chvec_t err_flag;
  dciv_chvec_t validate_pending;
  dciv_chvec_t halted;
  logic aw_held;
  logic w_held;
  logic [`DCIV_ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;

  // byte-lane masked channel bits of a write
  function automatic dciv_chvec_t lane_bits(input logic [31:0] d,
                                            input logic [3:0] s);
    logic [31:0] m;
    m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    lane_bits = dciv_chvec_t'(d & m); // reserved bits 31-19 dropped
  endfunction : lane_bits

  // ------------------------------------------------------------
  // write channel: address and data taken in either order
  // ------------------------------------------------------------
  logic wr_fire;
  logic [`DCIV_ADDR_W-1:0] wr_addr;
  dciv_chvec_t wr_bits;
  assign wr_fire = aw_held && w_held && !S_AXI_BVALID;
  assign wr_addr = aw_addr;
  assign wr_bits = lane_bits(w_data, w_strb);

  // capture address
  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      aw_held <= 1'b0;
      aw_addr <= '0;
      S_AXI_AWREADY <= 1'b0;
    end
    else
    begin
      S_AXI_AWREADY <= !aw_held && !S_AXI_AWREADY;
      if (S_AXI_AWVALID && S_AXI_AWREADY)
      begin
        aw_held <= 1'b1;
        aw_addr <= S_AXI_AWADDR;
        S_AXI_AWREADY <= 1'b0;
      end
      else if (wr_fire)
        aw_held <= 1'b0;
    end
  end

  // capture data
  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      w_held <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
      S_AXI_WREADY <= 1'b0;
    end
    else
    begin
      S_AXI_WREADY <= !w_held && !S_AXI_WREADY;
      if (S_AXI_WVALID && S_AXI_WREADY)
      begin
        w_held <= 1'b1;
        w_data <= S_AXI_WDATA;
        w_strb <= S_AXI_WSTRB;
        S_AXI_WREADY <= 1'b0;
      end
      else if (wr_fire)
        w_held <= 1'b0;
    end
  end

  // write response; unmapped or read-only offsets answer slverr
  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= `DCIV_RESP_OKAY;
    end
    else if (wr_fire)
    begin
      S_AXI_BVALID <= 1'b1;
      case (wr_addr)
        `DCIV_OFS_ERR_STATUS, `DCIV_OFS_IRQ_EN_SET, `DCIV_OFS_IRQ_EN_CLR,
        `DCIV_OFS_IRQ_A_STATUS, `DCIV_OFS_IRQ_B_STATUS,
        `DCIV_OFS_VALID_SET:
          S_AXI_BRESP <= `DCIV_RESP_OKAY;
        default:
          S_AXI_BRESP <= `DCIV_RESP_SLVERR;
      endcase
    end
    else if (S_AXI_BREADY)
      S_AXI_BVALID <= 1'b0;
  end

  // one strobe per writable register, high only in the cycle a write fires
  logic we_en_set, we_en_clr, we_a, we_b, we_err, we_valid;
  assign we_en_set = wr_fire && (wr_addr == `DCIV_OFS_IRQ_EN_SET);
  assign we_en_clr = wr_fire && (wr_addr == `DCIV_OFS_IRQ_EN_CLR);
  assign we_a = wr_fire && (wr_addr == `DCIV_OFS_IRQ_A_STATUS);
  assign we_b = wr_fire && (wr_addr == `DCIV_OFS_IRQ_B_STATUS);
  assign we_err = wr_fire && (wr_addr == `DCIV_OFS_ERR_STATUS);
  assign we_valid = wr_fire && (wr_addr == `DCIV_OFS_VALID_SET);

  // ------------------------------------------------------------
  // interrupt enables and status flags
  // ------------------------------------------------------------
  // set-style and clear-style writes share one enable vector
  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
      irq_enable <= `DCIV_CH_RESET;
    else if (we_en_set)
      irq_enable <= irq_enable | wr_bits;
    else if (we_en_clr)
      irq_enable <= irq_enable & ~wr_bits;
  end

  // hardware set requests of this cycle
  dciv_chvec_t set_a, set_b, set_err;
  assign set_a = DESC_EVENTS.exhausted & DESC_EVENTS.irq_a_request;
  assign set_b = DESC_EVENTS.exhausted & DESC_EVENTS.irq_b_request;
  assign set_err = DESC_EVENTS.error;

  // clear first, then or in the set so a same-cycle event survives
  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      irq_a_flag <= `DCIV_CH_RESET;
      irq_b_flag <= `DCIV_CH_RESET;
      err_flag <= `DCIV_CH_RESET;
    end
    else
    begin
      irq_a_flag <= (irq_a_flag & ~(we_a ? wr_bits : '0))
                    | set_a;
      irq_b_flag <= (irq_b_flag & ~(we_b ? wr_bits : '0))
                    | set_b;
      err_flag <= (err_flag & ~(we_err ? wr_bits : '0))
                  | set_err;
    end
  end

  // registered so the pin comes straight from a flip-flop
  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
      DMA_IRQ <= 1'b0;
    else
      DMA_IRQ <= |(((irq_a_flag | irq_b_flag) & irq_enable)
                   | err_flag);
  end

  // ------------------------------------------------------------
  // descriptor validation
  // ------------------------------------------------------------
  dciv_chvec_t next_pending, next_halted, release_go;
  // per channel: release on valid bit, else on pending, else halt
  always_comb
  begin
    next_pending = validate_pending | (we_valid ? wr_bits : '0);
    next_halted = halted;
    release_go = '0;
    for (int c = 0; c < NUM_CH; c++)
    begin
      if (DESC_CHECK.check[c] && DESC_CHECK.valid_bit[c])
        release_go[c] = 1'b1;
      else if ((DESC_CHECK.check[c] || halted[c]) && next_pending[c])
      begin
        release_go[c] = 1'b1;
        next_pending[c] = 1'b0;
        next_halted[c] = 1'b0;
      end
      else if (DESC_CHECK.check[c])
        next_halted[c] = 1'b1;
    end
  end

  // pending, halt and one-cycle go pulses
  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      validate_pending <= `DCIV_CH_RESET;
      halted <= `DCIV_CH_RESET;
      DESC_GO <= `DCIV_CH_RESET;
      DESC_HOLD <= `DCIV_CH_RESET;
    end
    else
    begin
      validate_pending <= next_pending;
      halted <= next_halted;
      DESC_GO <= release_go;
      DESC_HOLD <= next_halted;
    end
  end

  // ------------------------------------------------------------
  // read channel
  // ------------------------------------------------------------
  // one read at a time; ready may toggle while idle, which axi allows
  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= '0;
      S_AXI_RRESP <= `DCIV_RESP_OKAY;
    end
    else
    begin
      S_AXI_ARREADY <= !S_AXI_RVALID && !S_AXI_ARREADY;
      if (S_AXI_ARVALID && S_AXI_ARREADY)
      begin
        S_AXI_ARREADY <= 1'b0;
        S_AXI_RVALID <= 1'b1;
        S_AXI_RRESP <= `DCIV_RESP_OKAY;
        case (S_AXI_ARADDR)
          `DCIV_OFS_ERR_STATUS: S_AXI_RDATA <= 32'(err_flag);
          `DCIV_OFS_IRQ_EN_SET: S_AXI_RDATA <= 32'(irq_enable);
          `DCIV_OFS_IRQ_A_STATUS: S_AXI_RDATA <= 32'(irq_a_flag);
          `DCIV_OFS_IRQ_B_STATUS: S_AXI_RDATA <= 32'(irq_b_flag);
          `DCIV_OFS_EVENT_STATUS: S_AXI_RDATA <= 32'(halted);
          `DCIV_OFS_IRQ_EN_CLR, `DCIV_OFS_VALID_SET:
            S_AXI_RDATA <= 32'h00000000; // write-only registers read zero
          default:
          begin
            S_AXI_RDATA <= 32'h00000000;
            S_AXI_RRESP <= `DCIV_RESP_SLVERR;
          end
        endcase
      end
      else if (S_AXI_RVALID && S_AXI_RREADY)
        S_AXI_RVALID <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  set_wins_a: assert property (
    @(posedge SYS_CLK) disable iff (!RESETN)
    (set_a[0] && we_a && wr_bits[0]) |=> irq_a_flag[0])
    else $error("interrupt a event lost to clear");
  flag_a_set_a: assert property (
    @(posedge SYS_CLK) disable iff (!RESETN)
    set_a != '0 |=> (irq_a_flag & $past(set_a)) == $past(set_a))
    else $error("interrupt a flag not set");
  flag_b_set_a: assert property (
    @(posedge SYS_CLK) disable iff (!RESETN)
    set_b != '0 |=> (irq_b_flag & $past(set_b)) == $past(set_b))
    else $error("interrupt b flag not set");
  clear_a_a: assert property (
    @(posedge SYS_CLK) disable iff (!RESETN)
    (we_a && set_a == '0) |=> (irq_a_flag & $past(wr_bits)) == '0)
    else $error("interrupt a flag not cleared");
  clear_b_a: assert property (
    @(posedge SYS_CLK) disable iff (!RESETN)
    (we_b && set_b == '0) |=> (irq_b_flag & $past(wr_bits)) == '0)
    else $error("interrupt b flag not cleared");
  enable_set_a: assert property (
    @(posedge SYS_CLK) disable iff (!RESETN)
    we_en_set |=> (irq_enable & $past(wr_bits)) == $past(wr_bits))
    else $error("enable not set");
  enable_clear_a: assert property (
    @(posedge SYS_CLK) disable iff (!RESETN)
    we_en_clr |=> (irq_enable & $past(wr_bits)) == '0)
    else $error("enable not cleared");
  irq_gate_a: assert property (
    @(posedge SYS_CLK) disable iff (!RESETN)
    ((irq_a_flag & ~irq_enable) != '0 && err_flag == '0
     && ((irq_a_flag | irq_b_flag) & irq_enable) == '0) |=> !DMA_IRQ)
    else $error("disabled interrupt reached output");
  irq_error_a: assert property (
    @(posedge SYS_CLK) disable iff (!RESETN)
    err_flag != '0 |=> DMA_IRQ)
    else $error("error flag did not raise interrupt");
  halt_release_a: assert property (
    @(posedge SYS_CLK) disable iff (!RESETN)
    (halted[0] && we_valid && wr_bits[0])
    |=> DESC_GO[0] ##1 !DESC_HOLD[0])
    else $error("halted channel not released");
  pending_use_a: assert property (
    @(posedge SYS_CLK) disable iff (!RESETN)
    (DESC_CHECK.check[0] && !DESC_CHECK.valid_bit[0] && validate_pending[0])
    |=> DESC_GO[0] && !validate_pending[0])
    else $error("buffered pending not consumed");
  valid_go_a: assert property (
    @(posedge SYS_CLK) disable iff (!RESETN)
    (DESC_CHECK.check[0] && DESC_CHECK.valid_bit[0])
    |=> DESC_GO[0] && !DESC_HOLD[0])
    else $error("valid descriptor not released");
  read_enable_a: assert property (
    @(posedge SYS_CLK) disable iff (!RESETN)
    (S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR == `DCIV_OFS_IRQ_EN_SET)
    |=> S_AXI_RDATA == 32'($past(irq_enable)))
    else $error("enable read does not match state");
  pending_set_a: assert property (
    @(posedge SYS_CLK) disable iff (!RESETN)
    (we_valid && wr_bits[0] && !halted[0] && !DESC_CHECK.check[0])
    |=> validate_pending[0])
    else $error("validate pending not buffered");
  hold_keep_a: assert property (
    @(posedge SYS_CLK) disable iff (!RESETN)
    (halted != '0 && !we_valid)
    |=> (halted & $past(halted)) == $past(halted))
    else $error("halted channel left without release");

endmodule : dciv_dma_irq_valid

/* testbench/dciv_dma_irq_valid_tb.sv */
// dciv_dma_irq_valid_tb.sv: self-checking bench for the dma channel
// interrupt and validation block, driven over axi4-lite.
// assumes dciv_pkg and dciv_regs.svh are compiled first; one clock.
`include "dciv_regs.svh"

module dciv_dma_irq_valid_tb
  import dciv_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ------------------------------------------------------------
  // stimulus signals, each given a value at time zero, and observed signals
  // ------------------------------------------------------------
  localparam logic [1:0] OK = `DCIV_RESP_OKAY;
  localparam logic [1:0] BAD = `DCIV_RESP_SLVERR;
  logic SYS_CLK = 1'b0;
  logic RESETN = 1'b0;
  logic [7:0] S_AXI_AWADDR = 8'h00;
  logic [7:0] S_AXI_ARADDR = 8'h00;
  logic [31:0] S_AXI_WDATA = 32'h00000000;
  logic [3:0] S_AXI_WSTRB = 4'hF;
  logic S_AXI_AWVALID = 1'b0;
  logic S_AXI_WVALID = 1'b0;
  logic S_AXI_BREADY = 1'b0;
  logic S_AXI_ARVALID = 1'b0;
  logic S_AXI_RREADY = 1'b0;
  logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY;
  logic S_AXI_RVALID, DMA_IRQ;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
  logic [31:0] S_AXI_RDATA;
  dciv_events_t DESC_EVENTS = '0;
  dciv_desc_t DESC_CHECK = '0;
  dciv_chvec_t DESC_GO, DESC_HOLD;
  int num_errors = 0;
  int check_count = 0;
  int cycles = 0;
  // go and hold as they stood while the last write response was shown
  dciv_chvec_t b_go = '0;
  dciv_chvec_t b_hold = '0;

  dciv_dma_irq_valid dut (.SYS_CLK(SYS_CLK), .RESETN(RESETN),
    .S_AXI_AWADDR(S_AXI_AWADDR), .S_AXI_AWVALID(S_AXI_AWVALID),
    .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WDATA(S_AXI_WDATA),
    .S_AXI_WSTRB(S_AXI_WSTRB), .S_AXI_WVALID(S_AXI_WVALID),
    .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP),
    .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
    .S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARVALID(S_AXI_ARVALID),
    .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA),
    .S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RVALID(S_AXI_RVALID),
    .S_AXI_RREADY(S_AXI_RREADY), .DESC_EVENTS(DESC_EVENTS),
    .DESC_CHECK(DESC_CHECK), .DESC_GO(DESC_GO), .DESC_HOLD(DESC_HOLD),
    .DMA_IRQ(DMA_IRQ));

  // 100 MHz clock; the cycle ceiling cuts a hung handshake short
  always #5 SYS_CLK = ~SYS_CLK;
  always @(posedge SYS_CLK)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      num_errors++;
      wrap_up();
    end
  end

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wrap_up();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up

  // ready is sampled at the falling edge, where it is settled, so the
  // handshake edge is known before valid is dropped after it
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er = OK,
                    input dciv_events_t ev = '0);
    bit ta;
    bit tw;
    bit da;
    bit dw;
    da = 1'b0;
    dw = 1'b0;
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= d;
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID <= 1'b1;
    while (!(da && dw))
    begin
      @(negedge SYS_CLK);
      ta = S_AXI_AWVALID && S_AXI_AWREADY;
      tw = S_AXI_WVALID && S_AXI_WREADY;
      @(posedge SYS_CLK);
      if (ta)
        S_AXI_AWVALID <= 1'b0;
      if (tw)
        S_AXI_WVALID <= 1'b0;
      da = da || ta;
      dw = dw || tw;
    end
    // an optional event meets the write in the cycle that it fires
    DESC_EVENTS <= ev;
    S_AXI_BREADY <= 1'b1;
    @(posedge SYS_CLK);
    DESC_EVENTS <= '0;
    do @(negedge SYS_CLK); while (S_AXI_BVALID !== 1'b1);
    check(S_AXI_BRESP, er);
    b_go = DESC_GO;
    b_hold = DESC_HOLD;
    @(posedge SYS_CLK);
    S_AXI_BREADY <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                    input logic [1:0] er = OK);
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'b1;
    do @(negedge SYS_CLK); while (S_AXI_ARREADY !== 1'b1);
    @(posedge SYS_CLK);
    S_AXI_ARVALID <= 1'b0;
    S_AXI_RREADY <= 1'b1;
    do @(negedge SYS_CLK); while (S_AXI_RVALID !== 1'b1);
    check(S_AXI_RDATA, ed);
    check(S_AXI_RRESP, er);
    @(posedge SYS_CLK);
    S_AXI_RREADY <= 1'b0;
  endtask : rd

  // one-cycle event pulse, then room for flag and interrupt to settle
  task automatic pulse(input dciv_events_t e);
    DESC_EVENTS <= e;
    @(posedge SYS_CLK);
    DESC_EVENTS <= '0;
    repeat (3) @(posedge SYS_CLK);
  endtask : pulse

  task automatic chk_irq(input logic exp);
    @(negedge SYS_CLK);
    check(DMA_IRQ, exp);
    @(posedge SYS_CLK);
  endtask : chk_irq

  task automatic look(input int ch, input logic go, input logic hold);
    @(negedge SYS_CLK);
    check(DESC_GO[ch], go);
    check(DESC_HOLD[ch], hold);
    @(posedge SYS_CLK);
  endtask : look

  // go is a one-cycle pulse, so a release by write is judged as it stood
  task automatic look_b(input int ch, input logic go, input logic hold);
    check(b_go[ch], go);
    check(b_hold[ch], hold);
  endtask : look_b

  task automatic desc_chk(input int ch, input logic vb, input logic go,
                          input logic hold);
    dciv_desc_t d;
    d = '0;
    d.check[ch] = 1'b1;
    d.valid_bit[ch] = vb;
    DESC_CHECK <= d;
    @(posedge SYS_CLK);
    DESC_CHECK <= '0;
    look(ch, go, hold);
  endtask : desc_chk

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    rd(`DCIV_OFS_IRQ_EN_SET, 32'h0);
    rd(`DCIV_OFS_IRQ_EN_CLR, 32'h0);
    rd(`DCIV_OFS_IRQ_A_STATUS, 32'h0);
    rd(`DCIV_OFS_IRQ_B_STATUS, 32'h0);
    rd(`DCIV_OFS_ERR_STATUS, 32'h0);
    rd(8'h44, 32'h0, BAD);
  endtask : t_reset

  task automatic t_enable();
    wr(`DCIV_OFS_IRQ_EN_SET, 32'h00040009);
    wr(`DCIV_OFS_IRQ_EN_SET, 32'h0);
    rd(`DCIV_OFS_IRQ_EN_SET, 32'h00040009);
    wr(`DCIV_OFS_IRQ_EN_CLR, 32'h00000008);
    wr(8'h30, 32'h00000007, BAD);
    rd(`DCIV_OFS_IRQ_EN_SET, 32'h00040001);
  endtask : t_enable

  // exhausted descriptor on one channel, request a or b, masked first
  task automatic t_irq(input int ch, input bit sel_b);
    dciv_events_t ev;
    logic [7:0] ofs;
    logic [31:0] bn;
    bn = 32'h1 << ch;
    ofs = sel_b ? `DCIV_OFS_IRQ_B_STATUS : `DCIV_OFS_IRQ_A_STATUS;
    ev = '0;
    ev.exhausted[ch] = 1'b1;
    wr(`DCIV_OFS_IRQ_EN_CLR, bn);
    pulse(ev);
    rd(ofs, 32'h0);
    ev.irq_a_request[ch] = !sel_b;
    ev.irq_b_request[ch] = sel_b;
    pulse(ev);
    rd(ofs, bn);
    chk_irq(1'b0);
    wr(`DCIV_OFS_IRQ_EN_SET, bn);
    chk_irq(1'b1);
    wr(ofs, 32'h0);
    rd(ofs, bn);
    wr(ofs, bn);
    rd(ofs, 32'h0);
    chk_irq(1'b0);
  endtask : t_irq

  // error flag on a masked channel still reaches the interrupt line
  task automatic t_error();
    dciv_events_t ev;
    ev = '0;
    ev.error[7] = 1'b1;
    pulse(ev);
    chk_irq(1'b1);
    rd(`DCIV_OFS_ERR_STATUS, 32'h00000080);
    wr(`DCIV_OFS_ERR_STATUS, 32'h00000080);
    rd(`DCIV_OFS_ERR_STATUS, 32'h0);
    chk_irq(1'b0);
  endtask : t_error

  // event and clear of interrupt a on channel 0 land in one cycle
  task automatic t_race();
    dciv_events_t ev;
    ev = '0;
    ev.exhausted[0] = 1'b1;
    ev.irq_a_request[0] = 1'b1;
    pulse(ev);
    wr(`DCIV_OFS_IRQ_A_STATUS, 32'h00000001, OK, ev);
    rd(`DCIV_OFS_IRQ_A_STATUS, 32'h00000001);
    chk_irq(1'b1);
    wr(`DCIV_OFS_IRQ_A_STATUS, 32'h00000001);
    rd(`DCIV_OFS_IRQ_A_STATUS, 32'h0);
    chk_irq(1'b0);
  endtask : t_race

  task automatic t_valid();
    desc_chk(0, 1'b1, 1'b1, 1'b0);
    desc_chk(2, 1'b1, 1'b1, 1'b0);
    wr(`DCIV_OFS_VALID_SET, 32'h0);
    desc_chk(5, 1'b0, 1'b0, 1'b1);
    look(5, 1'b0, 1'b1);
    rd(`DCIV_OFS_EVENT_STATUS, 32'h00000020);
    wr(`DCIV_OFS_VALID_SET, 32'h00000020);
    look_b(5, 1'b1, 1'b0);
    wr(`DCIV_OFS_VALID_SET, 32'h00000001);
    desc_chk(0, 1'b0, 1'b1, 1'b0);
    desc_chk(0, 1'b0, 1'b0, 1'b1);
    wr(`DCIV_OFS_VALID_SET, 32'h00000001);
    look_b(0, 1'b1, 1'b0);
    rd(`DCIV_OFS_VALID_SET, 32'h0);
    wr(`DCIV_OFS_EVENT_STATUS, 32'h00000001, BAD);
  endtask : t_valid

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    repeat (10) @(posedge SYS_CLK);
    RESETN <= 1'b1;
    repeat (2) @(posedge SYS_CLK);
    t_reset();
    t_enable();
    t_irq(3, 1'b0);
    t_irq(18, 1'b1);
    t_error();
    t_race();
    t_valid();
    wrap_up();
  end
endmodule : dciv_dma_irq_valid_tb
